// ### hw/ivm_params.svh
`ifndef IVM_PARAMS_SVH
`define IVM_PARAMS_SVH
// vector addresses in program memory (24-bit)
`define IVM_VEC_RESET 24'h00_8000
`define IVM_VEC_TRAP 24'h00_8004
`define IVM_VEC_IRQ_BASE 24'h00_8008
`define IVM_VEC_STRIDE 24'h00_0004
`define IVM_VEC_RSVD_LO 24'h00_806C
`define IVM_VEC_RSVD_HI 24'h00_807C
// number of irq lines
`define IVM_NUM_IRQ 25
// wakeup capability per irq, bit n = irq n
`define IVM_WAKE_HALT 25'h008_05F8
`define IVM_WAKE_AHALT 25'h008_05FA
// irq numbers with special meaning
`define IVM_IRQ_PORT_A 3
`endif

// ### hw/ivm_pkg.sv
package ivm_pkg;
  typedef logic [23:0] ivm_vec_t;
  typedef logic [4:0] ivm_irq_t;
  typedef enum logic [1:0] {
    IVM_RUN,
    IVM_HALT,
    IVM_AHALT
  } ivm_mode_e;
endpackage : ivm_pkg

// ### hw/ivm_prio_enc.sv
`include "ivm_params.svh"
// lowest-numbered pending request wins
module ivm_prio_enc #(
  parameter int N = `IVM_NUM_IRQ
) (
  // requests
  input wire logic [N-1:0] req,
  // winner
  output logic any,
  output ivm_pkg::ivm_irq_t idx
);
  // the winner index is five bits wide
  if (N < 1 || N > 32) begin : g_bad_n
    $error("ivm_prio_enc: N out of range");
  end
  always_comb begin
    any = 1'b0;
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        any = 1'b1;
        idx = ivm_pkg::ivm_irq_t'(i);
      end
    end
  end
endmodule : ivm_prio_enc

// ### hw/ivm_top.sv
`include "ivm_params.svh"
// Contract
// [R1] irq0 top-level pin, 8008, never wakes
// [R2] irq1 auto-wakeup, 800C, wakes active-halt only
// [R3] irq3 port A, 8014, wakes except bit one
// [R4] irq4-7 ports B-E, 8018-8024, wake both
// [R5] irq8 CAN rx wakes; irq9 CAN other doesn't
// [R6] irq10 SPI, 8030, wakes both modes
// [R7] irq11/12 advanced timer, non-waking
// [R8] irq13-16 general timers, non-waking
// [R9] irq17/18 and 20/21 serial ports, non-waking
// [R10] irq19 I2C, 8054, wakes both modes
// [R11] irq22 converter, irq23 basic timer, non-waking
// [R12] irq24 flash, irq2 clock, non-waking
// [R13] reset 8000, trap 8004, 806C-807C unused
// [R14] lowest pending irq number presented first
module ivm_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // core state
  input wire ivm_pkg::ivm_mode_e core_mode,
  input wire logic trap_req,
  input wire logic reset_fetch,
  // request lines, bit n = irq n, level, same clock
  input wire logic [`IVM_NUM_IRQ-1:0] irq_req,
  input wire logic [`IVM_NUM_IRQ-1:0] irq_en,
  // port A change came only from bit one
  input wire logic port_a_bit_one_only,
  // to core
  output logic vec_valid,
  output ivm_pkg::ivm_vec_t vec_addr,
  output ivm_pkg::ivm_irq_t vec_irq,
  output logic vec_is_irq,
  output logic wake
);
  typedef struct packed {
    logic valid;
    ivm_pkg::ivm_vec_t addr;
    ivm_pkg::ivm_irq_t irq;
    logic is_irq;
    logic wake;
  } ivm_state_s;
  typedef enum logic [1:0] {
    IVM_SRC_NONE,
    IVM_SRC_RESET,
    IVM_SRC_TRAP,
    IVM_SRC_IRQ
  } ivm_src_e;

  ivm_state_s state;
  ivm_state_s next_state;
  logic [`IVM_NUM_IRQ-1:0] pend;
  logic [`IVM_NUM_IRQ-1:0] wake_mask;
  logic any;
  ivm_pkg::ivm_irq_t win;
  ivm_src_e src;

  function automatic ivm_pkg::ivm_vec_t irq_vector(input ivm_pkg::ivm_irq_t n);
    // irq n sits one stride past irq n-1; reserved slots never produced
    irq_vector = `IVM_VEC_IRQ_BASE + 24'(n) * `IVM_VEC_STRIDE; // R1 R4 R8 R9 R13
  endfunction : irq_vector

  // wake capability of one line in one stop mode; port A bit one is masked at run time
  function automatic logic irq_wakes(input ivm_pkg::ivm_irq_t n, input logic active_halt);
    unique case (n)
      5'h00: irq_wakes = 1'b0; // R1
      5'h01: irq_wakes = active_halt; // R2
      5'h02: irq_wakes = 1'b0; // R12
      5'h03: irq_wakes = 1'b1; // R3
      5'h04: irq_wakes = 1'b1; // R4
      5'h05: irq_wakes = 1'b1; // R4
      5'h06: irq_wakes = 1'b1; // R4
      5'h07: irq_wakes = 1'b1; // R4
      5'h08: irq_wakes = 1'b1; // R5
      5'h09: irq_wakes = 1'b0; // R5
      5'h0A: irq_wakes = 1'b1; // R6
      5'h0B: irq_wakes = 1'b0; // R7
      5'h0C: irq_wakes = 1'b0; // R7
      5'h0D: irq_wakes = 1'b0; // R8
      5'h0E: irq_wakes = 1'b0; // R8
      5'h0F: irq_wakes = 1'b0; // R8
      5'h10: irq_wakes = 1'b0; // R8
      5'h11: irq_wakes = 1'b0; // R9
      5'h12: irq_wakes = 1'b0; // R9
      5'h13: irq_wakes = 1'b1; // R10
      5'h14: irq_wakes = 1'b0; // R9
      5'h15: irq_wakes = 1'b0; // R9
      5'h16: irq_wakes = 1'b0; // R11
      5'h17: irq_wakes = 1'b0; // R11
      5'h18: irq_wakes = 1'b0; // R12
      default: irq_wakes = 1'b0;
    endcase
  endfunction : irq_wakes

  // whole capability table of one stop mode, bit n = irq n
  function automatic logic [`IVM_NUM_IRQ-1:0] wake_table(input logic active_halt);
    logic [`IVM_NUM_IRQ-1:0] t;
    t = '0;
    for (int i = 0; i < `IVM_NUM_IRQ; i++) begin
      t[i] = irq_wakes(ivm_pkg::ivm_irq_t'(i), active_halt);
    end
    wake_table = t;
  endfunction : wake_table

  // the slots above the last irq vector
  function automatic logic in_reserved(input ivm_pkg::ivm_vec_t a);
    in_reserved = a >= `IVM_VEC_RSVD_LO && a <= `IVM_VEC_RSVD_HI;
  endfunction : in_reserved

  // the core fetches from fixed slots, so a header whose slots overlap or fall out of order is refused
  if (`IVM_NUM_IRQ < 1 || `IVM_NUM_IRQ > 32) begin : g_bad_count
    $error("ivm_top: irq count does not fit the irq number");
  end
  if ($bits(ivm_pkg::ivm_irq_t) < $clog2(`IVM_NUM_IRQ)) begin : g_bad_width
    $error("ivm_top: irq number too narrow for the request lines");
  end
  if (`IVM_IRQ_PORT_A >= `IVM_NUM_IRQ) begin : g_bad_port_a
    $error("ivm_top: port A irq outside the request lines");
  end
  if (`IVM_VEC_RESET + `IVM_VEC_STRIDE != `IVM_VEC_TRAP) begin : g_bad_trap
    $error("ivm_top: trap vector must follow the reset vector");
  end
  if (`IVM_VEC_TRAP + `IVM_VEC_STRIDE != `IVM_VEC_IRQ_BASE) begin : g_bad_base
    $error("ivm_top: irq vectors must follow the trap vector");
  end
  if (`IVM_VEC_RSVD_HI < `IVM_VEC_RSVD_LO) begin : g_bad_rsvd
    $error("ivm_top: reserved range is empty");
  end
  if (`IVM_VEC_IRQ_BASE + (`IVM_NUM_IRQ - 1) * `IVM_VEC_STRIDE >= `IVM_VEC_RSVD_LO) begin : g_bad_top
    $error("ivm_top: irq vectors run into the reserved slots");
  end
  if (wake_table(1'b0) != `IVM_WAKE_HALT) begin : g_bad_halt
    $error("ivm_top: halt wake mask disagrees with the per-irq table");
  end
  if (wake_table(1'b1) != `IVM_WAKE_AHALT) begin : g_bad_ahalt
    $error("ivm_top: active-halt wake mask disagrees with the per-irq table");
  end

  // no irq slot may land among the reserved ones
  for (genvar g = 0; g < `IVM_NUM_IRQ; g++) begin : g_slot
    if (in_reserved(irq_vector(ivm_pkg::ivm_irq_t'(g)))) begin : g_bad
      $error("ivm_top: an irq vector lands in a reserved slot");
    end
  end

  assign pend = irq_req & irq_en;

  ivm_prio_enc #(.N(`IVM_NUM_IRQ)) u_prio (
    .req(pend),
    .any(any),
    .idx(win)
  ); // R14

  always_comb begin
    // per-mode capability table; port A masked when only bit one changed
    unique case (core_mode)
      ivm_pkg::IVM_HALT: wake_mask = `IVM_WAKE_HALT; // R1 R2 R4 R5 R6 R10
      ivm_pkg::IVM_AHALT: wake_mask = `IVM_WAKE_AHALT; // R2 R7 R8 R9 R11 R12
      default: wake_mask = '0;
    endcase
    if (port_a_bit_one_only) begin
      wake_mask[`IVM_IRQ_PORT_A] = 1'b0; // R3
    end
  end

  // reset has top precedence, then trap, then irqs
  always_comb begin
    if (reset_fetch) begin
      src = IVM_SRC_RESET; // R13
    end else if (trap_req) begin
      src = IVM_SRC_TRAP; // R13
    end else if (any) begin
      src = IVM_SRC_IRQ; // R14
    end else begin
      src = IVM_SRC_NONE;
    end
  end

  always_comb begin
    next_state = state;
    next_state.wake = |(pend & wake_mask);
    unique case (src)
      IVM_SRC_RESET: begin
        next_state.valid = 1'b1;
        next_state.addr = `IVM_VEC_RESET; // R13
        next_state.irq = '0;
        next_state.is_irq = 1'b0;
        next_state.wake = core_mode != ivm_pkg::IVM_RUN; // R13
      end
      IVM_SRC_TRAP: begin
        next_state.valid = 1'b1;
        next_state.addr = `IVM_VEC_TRAP; // R13
        next_state.irq = '0;
        next_state.is_irq = 1'b0;
      end
      IVM_SRC_IRQ: begin
        next_state.valid = !in_reserved(irq_vector(win)); // R13
        next_state.addr = irq_vector(win); // R14
        next_state.irq = win;
        next_state.is_irq = 1'b1;
      end
      IVM_SRC_NONE: begin
        next_state.valid = 1'b0;
        next_state.is_irq = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign vec_valid = state.valid;
  assign vec_addr = state.addr;
  assign vec_irq = state.irq;
  assign vec_is_irq = state.is_irq;
  assign wake = state.wake;
endmodule : ivm_top

// ### verification/ivm_chk.sv
module ivm_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // requests
  input wire ivm_pkg::ivm_mode_e core_mode,
  input wire logic trap_req,
  input wire logic reset_fetch,
  input wire logic [24:0] irq_req,
  input wire logic [24:0] irq_en,
  input wire logic port_a_bit_one_only,
  // to core
  input wire logic vec_valid,
  input wire ivm_pkg::ivm_vec_t vec_addr,
  input wire ivm_pkg::ivm_irq_t vec_irq,
  input wire logic vec_is_irq,
  input wire logic wake
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [24:0] pend;
  logic [24:0] wmask;
  logic quiet;
  assign pend = irq_req & irq_en & ~(25'(port_a_bit_one_only) << 3);
  assign wmask = core_mode == ivm_pkg::IVM_AHALT ? 25'h008_05FA : 25'h008_05F8;
  assign quiet = !reset_fetch && !trap_req;
  a_irq_addr: assert property (vec_valid && vec_is_irq |-> vec_addr == 24'h00_8008 + 24'(vec_irq) * 4)
    else $error("irq vector address wrong");
  a_rst_vec: assert property (reset_fetch |=> vec_valid && vec_addr == 24'h00_8000 && !vec_is_irq)
    else $error("reset vector wrong");
  a_rst_wake: assert property (reset_fetch && core_mode != ivm_pkg::IVM_RUN |=> wake)
    else $error("reset does not wake");
  a_trap_vec: assert property (trap_req && !reset_fetch |=> vec_valid && vec_addr == 24'h00_8004 && !vec_is_irq)
    else $error("trap vector wrong");
  a_no_rsvd: assert property (vec_valid |-> vec_addr < 24'h00_806C)
    else $error("reserved vector presented");
  a_low_first: assert property (quiet && |(irq_req & irq_en) |=> vec_is_irq && (25'(1) << vec_irq) == $past(irq_req & irq_en & -(irq_req & irq_en)))
    else $error("not lowest pending irq");
  a_idle_none: assert property (quiet && !(|(irq_req & irq_en)) |=> !vec_valid)
    else $error("vector without request");
  a_run_nowake: assert property (core_mode == ivm_pkg::IVM_RUN |=> !wake)
    else $error("wake while running");
  a_wake_set: assert property (core_mode != ivm_pkg::IVM_RUN && !reset_fetch |=> wake == $past(|(pend & wmask)))
    else $error("wake set wrong");
endmodule : ivm_chk
bind ivm_top ivm_chk i_ivm_chk (
  .clk(clk),
  .rst_n(rst_n),
  .core_mode(core_mode),
  .trap_req(trap_req),
  .reset_fetch(reset_fetch),
  .irq_req(irq_req),
  .irq_en(irq_en),
  .port_a_bit_one_only(port_a_bit_one_only),
  .vec_valid(vec_valid),
  .vec_addr(vec_addr),
  .vec_irq(vec_irq),
  .vec_is_irq(vec_is_irq),
  .wake(wake)
);

// ### verification/ivm_core_model.sv
module ivm_core_model (
  // vector fetch
  input wire logic clk,
  input wire logic vec_valid,
  input wire ivm_pkg::ivm_vec_t vec_addr,
  output ivm_pkg::ivm_vec_t fetched
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk) if (vec_valid) fetched <= vec_addr;
endmodule : ivm_core_model

// ### verification/ivm_top_tb.sv
module ivm_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, trap_req = 0, reset_fetch = 0, port_a_bit_one_only = 0;
  ivm_pkg::ivm_mode_e core_mode = ivm_pkg::IVM_HALT;
  logic [24:0] irq_req = '0, irq_en = '0, mask;
  logic vec_valid, vec_is_irq, wake;
  ivm_pkg::ivm_vec_t vec_addr, fetched;
  ivm_pkg::ivm_irq_t vec_irq;
  int miscompares = 0, checked = 0;
  always #5 clk = ~clk;
  ivm_top i_ivm_top (
    .clk(clk),
    .rst_n(rst_n),
    .core_mode(core_mode),
    .trap_req(trap_req),
    .reset_fetch(reset_fetch),
    .irq_req(irq_req),
    .irq_en(irq_en),
    .port_a_bit_one_only(port_a_bit_one_only),
    .vec_valid(vec_valid),
    .vec_addr(vec_addr),
    .vec_irq(vec_irq),
    .vec_is_irq(vec_is_irq),
    .wake(wake)
  );
  ivm_core_model i_ivm_core_model (
    .clk(clk),
    .vec_valid(vec_valid),
    .vec_addr(vec_addr),
    .fetched(fetched)
  );
  task automatic cmp(input logic [25:0] got, input logic [25:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic step(input logic [24:0] r, input logic [24:0] e);
    @(negedge clk);
    irq_req = r;
    irq_en = e;
    @(negedge clk);
  endtask : step
  task automatic t_map;
    for (int m = 0; m < 2; m++) begin
      core_mode = m ? ivm_pkg::IVM_AHALT : ivm_pkg::IVM_HALT;
      mask = m ? 25'h008_05FA : 25'h008_05F8;
      for (int n = 0; n < 25; n++) begin
        step(25'(1) << n, '1);
        cmp({vec_valid, vec_addr, wake}, {1'b1, 24'h00_8008 + 24'(4 * n), mask[n]});
        cmp(26'({vec_is_irq, vec_irq}), 26'({1'b1, 5'(n)}));
        @(negedge clk);
        cmp(26'(fetched), 26'(24'h00_8008 + 24'(4 * n)));
      end
    end
  endtask : t_map
  task automatic t_pri;
    port_a_bit_one_only = 1;
    step(25'h8, '1);
    cmp({vec_valid, vec_addr, wake}, {1'b1, 24'h00_8014, 1'b0});
    step('1, 25'h1FF_FFF0);
    cmp({vec_valid, vec_addr, wake}, {1'b1, 24'h00_8018, 1'b1});
    core_mode = ivm_pkg::IVM_RUN;
    trap_req = 1;
    step('1, '1);
    cmp({vec_valid, vec_addr, wake}, {1'b1, 24'h00_8004, 1'b0});
    reset_fetch = 1;
    step('1, '1);
    cmp({vec_valid, vec_addr, wake}, {1'b1, 24'h00_8000, 1'b0});
    reset_fetch = 0;
    trap_req = 0;
    step('1, '0);
    cmp(26'(vec_valid), 26'h0);
  endtask : t_pri
  task automatic t_rst;
    core_mode = ivm_pkg::IVM_HALT;
    step(25'h10, '1);
    cmp({vec_valid, vec_addr, wake}, {1'b1, 24'h00_8018, 1'b1});
    rst_n = 0;
    @(negedge clk);
    cmp({vec_valid, vec_addr, wake}, 26'h0);
    cmp(26'({vec_is_irq, vec_irq}), 26'h0);
    rst_n = 1;
    reset_fetch = 1;
    step('0, '0);
    cmp({vec_valid, vec_addr, wake}, {1'b1, 24'h00_8000, 1'b1});
    reset_fetch = 0;
  endtask : t_rst
  task automatic wrap_up;
    $display("miscompares %0d checked %0d", miscompares, checked);
    if (miscompares == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1;
    t_map;
    t_pri;
    t_rst;
    wrap_up;
  end
endmodule : ivm_top_tb
